// ### bpa_pkg.sv
// constants and types shared by the bridge pwm auto-shutdown block
package bpa_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] OFS_SHUTDOWN   = 4'h0;
	localparam logic [3:0] OFS_CONFIG     = 4'h1;
	localparam logic [3:0] OFS_PERIOD     = 4'h2;
	localparam logic [3:0] OFS_TIMER_CTRL = 4'h3;
	localparam logic [3:0] OFS_TIMER_FLAG = 4'h4;
	localparam logic [3:0] OFS_POLARITY   = 4'h5;
	localparam logic [3:0] OFS_DIRECTION  = 4'h6;
	localparam logic [3:0] OFS_STATUS     = 4'h7;

	localparam int BIT_EVENT_STATUS = 7;
	localparam int SRC_LSB          = 4;
	localparam int AC_LSB           = 2;
	localparam int BD_LSB           = 0;
	localparam int BIT_RESTART      = 7;
	localparam int BIT_RUN          = 2;
	localparam int BIT_FLAG         = 0;
	localparam int LVL_TRI_BIT      = 1;

	localparam logic [7:0] RST_SHUTDOWN   = 8'h00;
	localparam logic [7:0] RST_CONFIG     = 8'h00;
	localparam logic [7:0] RST_PERIOD     = 8'hff;
	localparam logic [2:0] RST_TIMER_CTRL = 3'h0;
	localparam logic [1:0] RST_POLARITY   = 2'h0;
	localparam logic [3:0] RST_DIRECTION  = 4'hf;

	localparam logic [1:0] LVL_LOW    = 2'h0;
	localparam logic [1:0] LVL_HIGH   = 2'h1;
	localparam logic [1:0] PSC_DIV1   = 2'h0;
	localparam logic [1:0] PSC_DIV4   = 2'h1;
	localparam logic [3:0] PSC_LAST1  = 4'h0;
	localparam logic [3:0] PSC_LAST4  = 4'h3;
	localparam logic [3:0] PSC_LAST16 = 4'hf;

	typedef enum logic [1:0] {
		BPA_RUN  = 2'h0,
		BPA_SHUT = 2'h1,
		BPA_WAIT = 2'h3
	} bpa_out_state_type;
endpackage

// ### bpa_timer_if.sv
// link between the register side and the period timer
interface bpa_timer_if;
	logic       run;
	logic [1:0] prescale;
	logic [7:0] period;
	logic [7:0] count;
	logic       period_start;
	modport ctrl (output run, output prescale, output period, input count, input period_start);
	modport tmr (input run, input prescale, input period, output count, output period_start);
endinterface

// ### bpa_sync3.sv
// three-stage pin synchroniser with agreement filter
module bpa_sync3 import bpa_pkg::*; (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// pin and result
	input  wire logic async_in,
	output logic      sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} bpa_sync_state_type;

	bpa_sync_state_type st;
	bpa_sync_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// a change counts only once stages two and three agree
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.q;
endmodule

// ### bpa_period_timer.sv
// period timer with prescaler; pulses period_start at each wrap
module bpa_period_timer import bpa_pkg::*; (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// control link
	bpa_timer_if.tmr  tif
);
	typedef struct packed {
		logic [3:0] pre;
		logic [7:0] count;
		logic       start;
	} bpa_timer_state_type;

	bpa_timer_state_type st;
	bpa_timer_state_type next_st;

	function automatic logic [3:0] last_tick(input logic [1:0] psc);
		case (psc)
			PSC_DIV1: last_tick = PSC_LAST1;
			PSC_DIV4: last_tick = PSC_LAST4;
			default:  last_tick = PSC_LAST16;
		endcase
	endfunction

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		if (tif.run) begin
			if (st.pre >= last_tick(tif.prescale)) begin
				next_st.pre = '0;
				if (st.count == tif.period) begin
					next_st.count = '0;
					next_st.start = 1'b1;
				end else begin
					next_st.count = st.count + 8'h01;
				end
			end else begin
				next_st.pre = st.pre + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tif.count        = st.count;
	assign tif.period_start = st.start;
endmodule

// ### bridge_pwm_auto_shutdown.sv
// auto-shutdown and restart control for the four bridge pwm pins
//
// How it works
// - bit 7 of the shutdown register flags a shutdown; outputs held while set.
// - three-bit source select: one enable bit each for cmp1, cmp2 and the external pin, ORed.
// - pair A/C shutdown level: 00 low, 01 high, 1x released.
// - pair B/D shutdown level: 00 low, 01 high, 1x released.
// - with auto restart, flag clears by itself once the cause goes away.
// - without auto restart, flag stays set until firmware clears it.
// - after the flag clears, pwm resumes only at the next period start.
// - writes to the flag are ignored while a selected cause is active.
// - comparator causes are levels; flag cannot clear while one persists.
// - writing one to the flag forces shutdown like a hardware event.
// - polarity per pair; software sets it before enabling the pins.
// - in sleep the clock stops, so state freezes; pin levels freeze too unless a selected cause forces them.
// - in primary idle the block keeps running on its clock unchanged.
// - in other low-power modes the timer runs on the selected clock.
// - a shutdown cause forces the pins at once, with no clock edge.
// - flag set at a period start holds shutdown for that whole period.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
module bridge_pwm_auto_shutdown import bpa_pkg::*; (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [DATA_W-1:0] reg_rdata,
	// shutdown sources
	input  wire logic              cmp1_out,
	input  wire logic              cmp2_out,
	input  wire logic              ext_interrupt_zero_pin,
	// pwm waveform from the generator, active high, order a b c d
	input  wire logic [3:0]        pwm_wave,
	// bridge pins
	output logic                   pwm_out_a,
	output logic                   pwm_out_a_oe,
	output logic                   pwm_out_b,
	output logic                   pwm_out_b_oe,
	output logic                   pwm_out_c,
	output logic                   pwm_out_c_oe,
	output logic                   pwm_out_d,
	output logic                   pwm_out_d_oe
);
	typedef struct packed {
		logic [7:0]        shutdown_ctrl;
		logic [7:0]        pwm_config;
		logic [7:0]        period;
		logic [2:0]        timer_ctrl;
		logic              timer_flag;
		logic [1:0]        polarity;
		logic [3:0]        direction;
		bpa_out_state_type out_state;
		logic [3:0]        wave;
		logic [7:0]        rdata;
	} bpa_main_state_type;

	bpa_main_state_type st;
	bpa_main_state_type next_st;

	bpa_timer_if tif();

	logic [2:0] src_sync;
	logic [2:0] src_raw;
	logic       cond_raw;
	logic       cond_sync;
	logic       write_shutdown;
	logic       status;
	logic       restart;
	logic       shut_now;
	logic [3:0] pin_val;
	logic [3:0] pin_en;

	// a source counts only when its select bit is set; order cmp1, cmp2, ext
	function automatic logic cause_active(input logic [2:0] sel, input logic [2:0] src);
		cause_active = |(sel & src);
	endfunction

	assign src_raw = {ext_interrupt_zero_pin, cmp2_out, cmp1_out};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			bpa_sync3 u_sync (
				.ref_clk  (ref_clk),
				.nrst     (nrst),
				.async_in (src_raw[gi]),
				.sync_out (src_sync[gi])
			);
		end
	endgenerate

	bpa_period_timer u_timer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.tif     (tif.tmr)
	);

	assign tif.run      = st.timer_ctrl[BIT_RUN];
	assign tif.prescale = st.timer_ctrl[1:0];
	assign tif.period   = st.period;

	assign status         = st.shutdown_ctrl[BIT_EVENT_STATUS];
	assign restart        = st.pwm_config[BIT_RESTART];
	assign write_shutdown = reg_write && (reg_addr == OFS_SHUTDOWN);
	// raw pins feed the override so the pins react without waiting for a clock
	assign cond_raw  = cause_active(st.shutdown_ctrl[SRC_LSB +: 3], src_raw);
	assign cond_sync = cause_active(st.shutdown_ctrl[SRC_LSB +: 3], src_sync);

	always_comb begin
		next_st = st;
		// control registers
		if (reg_write) begin
			case (reg_addr)
				OFS_SHUTDOWN:   next_st.shutdown_ctrl[6:0] = reg_wdata[6:0];
				OFS_CONFIG:     next_st.pwm_config = reg_wdata;
				OFS_PERIOD:     next_st.period = reg_wdata;
				OFS_TIMER_CTRL: next_st.timer_ctrl = reg_wdata[2:0];
				OFS_TIMER_FLAG: next_st.timer_flag = reg_wdata[BIT_FLAG];
				OFS_POLARITY:   next_st.polarity = reg_wdata[1:0];
				OFS_DIRECTION:  next_st.direction = reg_wdata[3:0];
				default:        next_st.timer_flag = st.timer_flag;
			endcase
		end
		// the wrap wins over a software clear in the same cycle
		if (tif.period_start) begin
			next_st.timer_flag = 1'b1;
		end
		// shutdown flag: a live cause wins over any write
		if (cond_sync) begin
			next_st.shutdown_ctrl[BIT_EVENT_STATUS] = 1'b1;
		end else if (write_shutdown) begin
			next_st.shutdown_ctrl[BIT_EVENT_STATUS] = reg_wdata[BIT_EVENT_STATUS];
		end else if (restart && status) begin
			next_st.shutdown_ctrl[BIT_EVENT_STATUS] = 1'b0;
		end
		// output hold: released only on a period boundary
		case (st.out_state)
			BPA_RUN: begin
				if (status) begin
					next_st.out_state = BPA_SHUT;
				end
			end
			BPA_SHUT: begin
				if (!status) begin
					next_st.out_state = BPA_WAIT;
				end
			end
			BPA_WAIT: begin
				if (status) begin
					next_st.out_state = BPA_SHUT;
				end else if (tif.period_start) begin
					next_st.out_state = BPA_RUN;
				end
			end
			default: next_st.out_state = BPA_SHUT;
		endcase
		// registered normal waveform with polarity applied per pair
		next_st.wave = pwm_wave ^ {st.polarity[1], st.polarity[0],
			st.polarity[1], st.polarity[0]};
		// read data stands for the one cycle after the strobe only
		next_st.rdata = '0;
		if (reg_read) begin
			case (reg_addr)
				OFS_SHUTDOWN:   next_st.rdata = st.shutdown_ctrl;
				OFS_CONFIG:     next_st.rdata = st.pwm_config;
				OFS_PERIOD:     next_st.rdata = st.period;
				OFS_TIMER_CTRL: next_st.rdata = {5'h00, st.timer_ctrl};
				OFS_TIMER_FLAG: next_st.rdata = {7'h00, st.timer_flag};
				OFS_POLARITY:   next_st.rdata = {6'h00, st.polarity};
				OFS_DIRECTION:  next_st.rdata = {4'h0, st.direction};
				OFS_STATUS:     next_st.rdata = {shut_now, st.out_state, cond_sync, 1'b0,
					src_sync};
				default:        next_st.rdata = '0;
			endcase
		end
	end

	// one clock for everything: sleep stops it and freezes state, idle keeps it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st.shutdown_ctrl <= RST_SHUTDOWN;
			st.pwm_config    <= RST_CONFIG;
			st.period        <= RST_PERIOD;
			st.timer_ctrl    <= RST_TIMER_CTRL;
			st.timer_flag    <= 1'b0;
			st.polarity      <= RST_POLARITY;
			st.direction     <= RST_DIRECTION;
			st.out_state     <= BPA_RUN;
			st.wave          <= '0;
			st.rdata         <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign shut_now = cond_raw || status || (st.out_state != BPA_RUN);

	// pins a, c are pair 0 (even index); pins b, d are pair 1
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			logic [1:0] lvl;
			assign lvl = (gi % 2 == 0) ? st.shutdown_ctrl[AC_LSB +: 2]
				: st.shutdown_ctrl[BD_LSB +: 2];
			// direction bit set keeps the pin released until software enables it
			assign pin_en[gi] = !st.direction[gi] && !(shut_now && lvl[LVL_TRI_BIT]);
			assign pin_val[gi] = shut_now ? (lvl == LVL_HIGH) : st.wave[gi];
		end
	endgenerate

	assign pwm_out_a    = pin_val[0];
	assign pwm_out_b    = pin_val[1];
	assign pwm_out_c    = pin_val[2];
	assign pwm_out_d    = pin_val[3];
	assign pwm_out_a_oe = pin_en[0];
	assign pwm_out_b_oe = pin_en[1];
	assign pwm_out_c_oe = pin_en[2];
	assign pwm_out_d_oe = pin_en[3];
	assign reg_rdata    = st.rdata;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	force_low_a: assert property (
		(cond_raw && st.shutdown_ctrl[AC_LSB +: 2] == LVL_LOW && !st.direction[0])
			|-> (!pwm_out_a && pwm_out_a_oe))
		else $error("pin a not forced low by shutdown cause");
	high_pair_ac_a: assert property (
		(shut_now && st.shutdown_ctrl[AC_LSB +: 2] == LVL_HIGH && !st.direction[2])
			|-> (pwm_out_c && pwm_out_c_oe))
		else $error("pin c not driven high in shutdown");
	tristate_bd_a: assert property (
		(shut_now && st.shutdown_ctrl[BD_LSB + LVL_TRI_BIT]) |-> (!pwm_out_b_oe && !pwm_out_d_oe))
		else $error("pair b d still driven while released");
	event_sets_flag_a: assert property (
		cond_sync |=> status)
		else $error("shutdown cause did not set the flag");
	comparator_level_a: assert property (
		(src_sync[0] && st.shutdown_ctrl[SRC_LSB]) [*2] |-> status)
		else $error("flag clear while comparator one still active");
	write_ignored_a: assert property (
		(write_shutdown && !reg_wdata[BIT_EVENT_STATUS] && cond_sync) |=> status)
		else $error("flag cleared by write during active cause");
	auto_clear_a: assert property (
		(restart && status && !cond_sync && !write_shutdown) |=> !status)
		else $error("auto restart did not clear the flag");
	sticky_flag_a: assert property (
		(!restart && status && !cond_sync && !write_shutdown) |=> status)
		else $error("flag cleared without firmware");
	forced_shutdown_a: assert property (
		(write_shutdown && reg_wdata[BIT_EVENT_STATUS]) |=> status ##1 (st.out_state == BPA_SHUT))
		else $error("writing one did not force shutdown");
	resume_boundary_a: assert property (
		(st.out_state != BPA_RUN && !tif.period_start) |=> (st.out_state != BPA_RUN))
		else $error("outputs resumed away from a period start");
	whole_period_a: assert property (
		(tif.period_start && status) |=> (st.out_state == BPA_SHUT) && shut_now)
		else $error("flag at period start did not hold shutdown");
	polarity_path_a: assert property (
		(!shut_now && !st.direction[1])
			|-> (pwm_out_b == ($past(pwm_wave[1]) ^ $past(st.polarity[1]))))
		else $error("pin b polarity wrong in normal operation");
	polarity_ac_a: assert property (
		(!shut_now && !st.direction[2])
			|-> (pwm_out_c == ($past(pwm_wave[2]) ^ $past(st.polarity[0]))))
		else $error("pin c polarity wrong in normal operation");

	// pin levels, enables and the shutdown override
	release_ac_a: assert property (
		(shut_now && st.shutdown_ctrl[AC_LSB + LVL_TRI_BIT])
			|-> (!pwm_out_a_oe && !pwm_out_c_oe && !pwm_out_a && !pwm_out_c))
		else $error("pair a c still driven while released");
	high_pair_bd_a: assert property (
		(shut_now && st.shutdown_ctrl[BD_LSB +: 2] == LVL_HIGH && !st.direction[3])
			|-> (pwm_out_d && pwm_out_d_oe))
		else $error("pin d not driven high in shutdown");
	low_pair_bd_a: assert property (
		(shut_now && st.shutdown_ctrl[BD_LSB +: 2] == LVL_LOW && !st.direction[1])
			|-> (!pwm_out_b && pwm_out_b_oe))
		else $error("pin b not driven low in shutdown");
	direction_off_a: assert property (
		(st.direction & {pwm_out_d_oe, pwm_out_c_oe, pwm_out_b_oe, pwm_out_a_oe}) == 4'h0)
		else $error("pin driven while its direction bit releases it");
	source_off_a: assert property (
		(st.shutdown_ctrl[SRC_LSB +: 3] == '0 && !status && st.out_state == BPA_RUN)
			|-> !shut_now)
		else $error("shutdown applied with no source selected");
	ext_override_a: assert property (
		(ext_interrupt_zero_pin && st.shutdown_ctrl[SRC_LSB + 2]) |-> shut_now)
		else $error("external pin did not override the pins at once");

	// shutdown flag and output hold
	cmp2_sets_flag_a: assert property (
		(src_sync[1] && st.shutdown_ctrl[SRC_LSB + 1]) |=> status)
		else $error("comparator two cause did not set the flag");
	ext_sets_flag_a: assert property (
		(src_sync[2] && st.shutdown_ctrl[SRC_LSB + 2]) |=> status)
		else $error("external pin cause did not set the flag");
	flag_write_a: assert property (
		(write_shutdown && !cond_sync) |=> (status == $past(reg_wdata[BIT_EVENT_STATUS])))
		else $error("free flag write not taken");
	hold_to_wait_a: assert property (
		(st.out_state == BPA_SHUT && !status) |=> (st.out_state == BPA_WAIT))
		else $error("hold did not wait for a period start");

	// reset, timer and read port
	reset_value_a: assert property (
		$rose(nrst) |-> (st.shutdown_ctrl == RST_SHUTDOWN && pin_en == '0))
		else $error("shutdown register or pins not at reset state");
	wrap_flag_a: assert property (
		tif.period_start |=> st.timer_flag)
		else $error("period start did not set the timer flag");
	timer_flag_clear_a: assert property (
		(reg_write && reg_addr == OFS_TIMER_FLAG && !reg_wdata[BIT_FLAG] && !tif.period_start)
			|=> !st.timer_flag)
		else $error("timer flag write of zero not taken");
	timer_frozen_a: assert property (
		!tif.run |=> $stable(tif.count))
		else $error("period timer moved while stopped");
	wrap_point_a: assert property (
		(tif.run && tif.prescale == PSC_DIV1 && tif.count == tif.period) |=> tif.period_start)
		else $error("no period start at the period match");
	read_stands_a: assert property (
		!$past(reg_read) |-> (reg_rdata == '0))
		else $error("read data outside the cycle after a read");
	shutdown_read_a: assert property (
		$past(reg_read && reg_addr == OFS_SHUTDOWN)
			|-> (reg_rdata == $past(st.shutdown_ctrl)))
		else $error("shutdown register read back wrong");

	restart_cover: cover property (status && restart ##1 !status ##[1:600] st.out_state == BPA_RUN);
	firmware_cover: cover property (write_shutdown && !reg_wdata[BIT_EVENT_STATUS] && status
		&& !restart);
	tristate_cover: cover property (shut_now && st.shutdown_ctrl[AC_LSB + LVL_TRI_BIT]);
	ext_cover: cover property (src_sync[2] && st.shutdown_ctrl[SRC_LSB + 2] ##1 status);
	polarity_cover: cover property (!shut_now && st.polarity != '0 && pin_en != '0);
endmodule

// ### bpa_bridge_model.sv
// bridge drivers and comparators seen from the four pwm pins
module bpa_bridge_model (
	// pins from the block
	input  wire logic [3:0] pin,
	input  wire logic [3:0] oe,
	// fault levels commanded by the bench, order {ext, cmp2, cmp1}
	input  wire logic [2:0] fault,
	// resolved bridge levels and trip outputs
	output logic      [3:0] bus,
	output logic            cmp1_out,
	output logic            cmp2_out,
	output logic            ext_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// released pins sit on the gate pull-downs so the switches stay off
	assign bus = pin & oe;
	// trips follow the sensed level with no latching of their own
	assign {ext_pin, cmp2_out, cmp1_out} = fault;
endmodule

// ### testbench.sv
// self-checking bench for the bridge pwm auto-shutdown block
module testbench;
	import bpa_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic              ref_clk   = 1'b0;
	logic              nrst      = 1'b0;
	logic [ADDR_W-1:0] reg_addr  = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_write = 1'b0;
	logic              reg_read  = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [3:0]        pwm_wave  = 4'h6;
	logic [2:0]        fault     = 3'h0;
	logic              cmp1_out;
	logic              cmp2_out;
	logic              ext_pin;
	logic [3:0]        pin;
	logic [3:0]        oe;
	logic [3:0]        bus;
	logic [1:0]        pol       = 2'h0;
	logic [1:0]        ac        = 2'h0;
	logic [1:0]        bd        = 2'h0;
	logic [2:0]        src;
	logic [7:0]        d;
	bit                ok;
	int                bad_count       = 0;
	int                samples_checked = 0;
	int                cycles          = 0;

	bridge_pwm_auto_shutdown bridge_pwm_auto_shutdown_i (
		.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .ext_interrupt_zero_pin(ext_pin),
		.pwm_wave(pwm_wave), .pwm_out_a(pin[0]), .pwm_out_a_oe(oe[0]),
		.pwm_out_b(pin[1]), .pwm_out_b_oe(oe[1]), .pwm_out_c(pin[2]),
		.pwm_out_c_oe(oe[2]), .pwm_out_d(pin[3]), .pwm_out_d_oe(oe[3])
	);

	bpa_bridge_model bpa_bridge_model_i (
		.pin(pin), .oe(oe), .fault(fault), .bus(bus),
		.cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .ext_pin(ext_pin)
	);

	always #12.5 ref_clk = ~ref_clk;

	// a hung handshake must still reach the report
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("wrong value at %0t: run timed out", $time);
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	// expected {oe, bus}: a and c follow the a/c level, b and d the b/d level
	function automatic logic [7:0] exp_pins(input bit shut);
		logic [1:0] lv;
		exp_pins = '0;
		for (int i = 0; i < 4; i++) begin
			lv = (i % 2 == 0) ? ac : bd;
			exp_pins[i] = shut ? (!lv[1] && lv[0]) : (pwm_wave[i] ^ pol[i % 2]);
			exp_pins[i + 4] = shut ? !lv[1] : 1'b1;
		end
	endfunction

	task automatic pins(input bit shut, input string msg);
		check({oe, bus}, exp_pins(shut), msg);
	endtask

	task automatic wait_flag(input bit v);
		rd(OFS_SHUTDOWN, d);
		for (int k = 0; k < 20 && d[7] !== v; k++) rd(OFS_SHUTDOWN, d);
		check({7'h0, d[7]}, {7'h0, v}, "event status");
	endtask

	// pins may turn normal only once a period start has set the timer flag
	task automatic resume;
		ok = 1'b0;
		for (int k = 0; k < 60 && !ok; k++) begin
			ok = ({oe, bus} === exp_pins(1'b0));
			rd(OFS_TIMER_FLAG, d);
			if (ok) check({7'h0, d[0]}, 8'h01, "resume off period start");
		end
		pins(1'b0, "resume");
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(OFS_SHUTDOWN, d);
		check(d, 8'h00, "shutdown reset");
		check({oe, bus}, 8'h00, "pins released after reset");
		wr(4'h9, 8'hff);
		rd(4'h9, d);
		check(d, 8'h00, "unmapped");
		wr(OFS_DIRECTION, 8'h0f);
		wr(OFS_PERIOD, 8'h0f);
		wr(OFS_POLARITY, 8'h00);
		wr(OFS_SHUTDOWN, 8'h90);
		wr(OFS_TIMER_FLAG, 8'h00);
		wr(OFS_TIMER_CTRL, 8'h04);
		rd(OFS_TIMER_FLAG, d);
		for (int k = 0; k < 40 && d[0] !== 1'b1; k++) rd(OFS_TIMER_FLAG, d);
		check({7'h0, d[0]}, 8'h01, "first period wrap");
		wr(OFS_DIRECTION, 8'h00);
		#1;
		pins(1'b1, "software forced shutdown");
		wr(OFS_TIMER_FLAG, 8'h00);
		wr(OFS_SHUTDOWN, 8'h10);
		resume();
		// an unselected comparator must not trip
		@(posedge ref_clk);
		fault <= 3'h2;
		repeat (10) @(posedge ref_clk);
		#1;
		pins(1'b0, "unselected source");
		wait_flag(1'b0);
		fault <= 3'h0;
		wr(OFS_CONFIG, 8'h80);
		for (int s = 1; s < 8; s++) begin
			src = s[2:0];
			ac = 2'(s % 3);
			bd = 2'((s + 1) % 3);
			wr(OFS_SHUTDOWN, {1'b0, src, ac, bd});
			@(posedge ref_clk);
			fault <= src[0] ? 3'h1 : (src[1] ? 3'h2 : 3'h4);
			#1;
			pins(1'b1, "immediate shutdown");
			wait_flag(1'b1);
			wr(OFS_SHUTDOWN, {1'b0, src, ac, bd});
			rd(OFS_SHUTDOWN, d);
			check(d, {1'b1, src, ac, bd}, "status write under fault");
			wr(OFS_TIMER_FLAG, 8'h00);
			fault <= 3'h0;
			wait_flag(1'b0);
			resume();
		end
		// without auto restart the status outlives its cause
		wr(OFS_CONFIG, 8'h00);
		ac = 2'h1;
		bd = 2'h2;
		wr(OFS_SHUTDOWN, 8'h16);
		fault <= 3'h1;
		wait_flag(1'b1);
		@(posedge ref_clk);
		fault <= 3'h0;
		repeat (30) @(posedge ref_clk);
		wait_flag(1'b1);
		pins(1'b1, "held without restart");
		rd(OFS_STATUS, d);
		check(d, {1'b1, BPA_SHUT, 5'h00}, "status while held");
		wr(OFS_TIMER_FLAG, 8'h00);
		wr(OFS_SHUTDOWN, 8'h16);
		wait_flag(1'b0);
		resume();
		// polarity is changed only while the pins are released
		wr(OFS_DIRECTION, 8'h0f);
		wr(OFS_POLARITY, 8'h03);
		pol = 2'h3;
		wr(OFS_DIRECTION, 8'h00);
		repeat (2) @(posedge ref_clk);
		#1;
		pins(1'b0, "inverted polarity");
		end_sim();
	end
endmodule
